// file: src/rsv_pkg.sv
`default_nettype none

package rsv_pkg;

  // ---------------------------------------------------------------------
  // Bus shape
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int NUM_RW = 2;
  localparam int CMD_W  = 4;
  localparam int STAT_W = 4;

  // ---------------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------------
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_MODE = 3'h1;
  localparam logic [2:0] IDX_STAT = 3'h2;
  localparam logic [2:0] IDX_CMD  = 3'h3;
  localparam logic [2:0] IDX_LAST = 3'h3;

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int CTRL_R0C   = 4;
  localparam int CTRL_R0S   = 5;
  localparam int CTRL_R1S   = 6;
  localparam int CTRL_R1C   = 7;
  localparam int MODE_ONE_L  = 0;
  localparam int MODE_ZERO_L = 2;
  localparam int MODE_X0_L  = 4;
  localparam int MODE_X1_L  = 6;
  localparam logic [7:0] RST_CTRL = 8'h40;
  localparam logic [7:0] RST_MODE = 8'hc0;
  localparam logic [7:0] ZERO_D   = 8'h00;
  localparam logic [7:0] ONES_D   = 8'hff;

  // ---------------------------------------------------------------------
  // Per-bit implementation kinds
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    KIND_NORM,
    KIND_READ_ONE,
    KIND_READ_ZERO,
    KIND_R0_CONST,
    KIND_R0_STORE,
    KIND_R1_CONST,
    KIND_R1_STORE,
    KIND_CTX0,
    KIND_CTX1
  } rsv_kind_type;

  // Per-field choice of implementation for the two read-write registers.
  function automatic rsv_kind_type bit_kind(input int r, input int b);
    rsv_kind_type k;
    k = KIND_NORM;
    if (r == 0)
    begin
      if (b == CTRL_R0C)      k = KIND_R0_CONST;
      else if (b == CTRL_R0S) k = KIND_R0_STORE;
      else if (b == CTRL_R1S) k = KIND_R1_STORE;
      else if (b == CTRL_R1C) k = KIND_R1_CONST;
    end
    else
    begin
      if (b < MODE_ZERO_L)     k = KIND_READ_ONE;
      else if (b < MODE_X0_L)  k = KIND_READ_ZERO;
      else if (b < MODE_X1_L)  k = KIND_CTX0;
      else                     k = KIND_CTX1;
    end
    return k;
  endfunction

  function automatic logic [7:0] reset_of(input int r);
    return (r == 0) ? RST_CTRL : RST_MODE;
  endfunction

endpackage

`default_nettype wire

// file: src/rsv_bit_cell.sv
`default_nettype none

module rsv_bit_cell #(
  parameter rsv_pkg::rsv_kind_type KIND    = rsv_pkg::KIND_NORM,
  parameter logic                  RST_BIT = 1'b0
) (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic dir_we_i,
  input  wire logic dir_bit_i,
  input  wire logic ind_we_i,
  input  wire logic ind_bit_i,
  input  wire logic rsv_now_i,
  output logic      rd_bit_o,
  output logic      use_bit_o
);

  // ---------------------------------------------------------------------
  // Storage or constant
  // ---------------------------------------------------------------------
  localparam bit IS_CONST = (KIND == rsv_pkg::KIND_READ_ONE) ||
                            (KIND == rsv_pkg::KIND_READ_ZERO) ||
                            (KIND == rsv_pkg::KIND_R0_CONST) ||
                            (KIND == rsv_pkg::KIND_R1_CONST);
  localparam bit CONST_V  = (KIND == rsv_pkg::KIND_READ_ONE) ||
                            (KIND == rsv_pkg::KIND_R1_CONST);
  localparam bit FORCE_1  = (KIND == rsv_pkg::KIND_R1_STORE) ||
                            (KIND == rsv_pkg::KIND_CTX1);
  localparam bit ALWAYS_R = (KIND == rsv_pkg::KIND_R0_STORE) ||
                            (KIND == rsv_pkg::KIND_R1_STORE);
  localparam bit CTX_R    = (KIND == rsv_pkg::KIND_CTX0) ||
                            (KIND == rsv_pkg::KIND_CTX1);

  logic reserved;

  // A context bit is reserved only while the qualifier says so.
  assign reserved = ALWAYS_R || (CTX_R && rsv_now_i);

  generate
    if (IS_CONST)
    begin : g_const
      // No flop: the written data is simply discarded.
      assign rd_bit_o  = CONST_V;
      assign use_bit_o = 1'b0;
    end
    else
    begin : g_store
      logic store_q;

      // Direct writes win over a same-cycle indirect update; an indirect
      // update of a reserved bit lands its forced value.
      always_ff @(posedge sys_clk_i)
      begin
        if (reset_i)
          store_q <= RST_BIT;
        else if (dir_we_i)
          store_q <= dir_bit_i;
        else if (ind_we_i)
          store_q <= reserved ? FORCE_1 : ind_bit_i;
      end

      assign rd_bit_o  = store_q;
      // A reserved value must not steer anything but its own readback.
      assign use_bit_o = reserved ? 1'b0 : store_q;
    end
  endgenerate

endmodule

`default_nettype wire

// file: src/rsv_regbank.sv
// Summary of operation
// - Read-as-one fields always read all ones, whatever was written.
// - Read-as-zero fields always read all zeros, whatever was written.
// - Constant reserved-zero bit reads 0 and ignores writes.
// - Indirect update forces a stored reserved-zero bit to zero.
// - Stored reserved bit reads last written value, else its reset value.
// - Direct write of a stored reserved bit updates its own flop.
// - A reserved bit's value drives nothing except its readback.
// - Constant or storage form is chosen separately for every field.
// - Context-reserved bits are always stored and read last write.
// - Constant reserved-one bit reads 1 and ignores writes.
// - Indirect update forces a stored reserved-one bit to one.
// - Reserved bits of a read-only register read zero, value untrusted.
// - Reserved positions: preserve in read-write, zero in write-only, zero-read in RO.
// - Reserved register accesses are harmless: read zero, writes drop.
// - Ignored writes leave the field with its previous value.

`default_nettype none

module rsv_regbank (
  input  wire logic                       sys_clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       wr_en_i,
  input  wire logic                       rd_en_i,
  input  wire logic [rsv_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [rsv_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                       ind_we_i,
  input  wire logic [rsv_pkg::ADDR_W-1:0] ind_addr_i,
  input  wire logic [rsv_pkg::DATA_W-1:0] ind_data_i,
  input  wire logic                       ctx_rsv_i,
  input  wire logic [rsv_pkg::STAT_W-1:0] status_i,
  output logic      [rsv_pkg::DATA_W-1:0] rd_data_o,
  output logic                            rd_valid_o,
  output logic      [2*rsv_pkg::DATA_W-1:0] ctrl_o,
  output logic      [rsv_pkg::CMD_W-1:0]  cmd_pulse_o
);

  // ---------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------
  function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
    return a == idx;
  endfunction

  logic [rsv_pkg::NUM_RW-1:0] dir_we;
  logic [rsv_pkg::NUM_RW-1:0] ind_we;
  logic [rsv_pkg::DATA_W-1:0] rw_rd [rsv_pkg::NUM_RW];
  logic [2*rsv_pkg::DATA_W-1:0] use_bits;
  logic [rsv_pkg::DATA_W-1:0] rd_data_d;
  logic [rsv_pkg::DATA_W-1:0] rd_data_q;
  logic                       rd_valid_q;
  logic [2*rsv_pkg::DATA_W-1:0] ctrl_q;
  logic [rsv_pkg::CMD_W-1:0]  cmd_q;

  // ---------------------------------------------------------------------
  // Field cells of the read-write registers
  // ---------------------------------------------------------------------
  // Every bit gets its own kind, so storage is only spent where wanted.
  genvar r, b;
  generate
    for (r = 0; r < rsv_pkg::NUM_RW; r++)
    begin : g_reg
      assign dir_we[r] = wr_en_i && hit(addr_i, 3'(r));
      assign ind_we[r] = ind_we_i && hit(ind_addr_i, 3'(r));
      for (b = 0; b < rsv_pkg::DATA_W; b++)
      begin : g_bit
        // The whole reset byte is named first, since a bit select cannot
        // be taken straight off a function call.
        localparam logic [rsv_pkg::DATA_W-1:0] RST_BYTE =
          rsv_pkg::reset_of(r);
        rsv_bit_cell #(
          .KIND    (rsv_pkg::bit_kind(r, b)),
          .RST_BIT (RST_BYTE[b])
        ) u_cell (
          .sys_clk_i (sys_clk_i),
          .reset_i   (reset_i),
          .dir_we_i  (dir_we[r]),
          .dir_bit_i (wr_data_i[b]),
          .ind_we_i  (ind_we[r]),
          .ind_bit_i (ind_data_i[b]),
          .rsv_now_i (ctx_rsv_i),
          .rd_bit_o  (rw_rd[r][b]),
          .use_bit_o (use_bits[r*rsv_pkg::DATA_W+b])
        );
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------
  // Status reserved bits read zero; command and unmapped reads read zero.
  always_comb
  begin
    rd_data_d = rsv_pkg::ZERO_D;
    if (hit(addr_i, rsv_pkg::IDX_CTRL))
      rd_data_d = rw_rd[0];
    else if (hit(addr_i, rsv_pkg::IDX_MODE))
      rd_data_d = rw_rd[1];
    else if (hit(addr_i, rsv_pkg::IDX_STAT))
      rd_data_d = {4'h0, status_i};
    else
      rd_data_d = rsv_pkg::ZERO_D;
  end

  // Read data is held until the next read so software samples it at will.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      rd_data_q <= rsv_pkg::ZERO_D;
    else if (rd_en_i)
      rd_data_q <= rd_data_d;
  end

  // Read answer strobe, one cycle after the request.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      rd_valid_q <= 1'b0;
    else
      rd_valid_q <= rd_en_i;
  end

  // ---------------------------------------------------------------------
  // Control outputs and command pulses
  // ---------------------------------------------------------------------
  // Registered so reserved gating never glitches downstream logic.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      ctrl_q <= '0;
    else
      ctrl_q <= use_bits;
  end

  // Upper command bits are reserved-zero and simply dropped.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      cmd_q <= '0;
    else if (wr_en_i && hit(addr_i, rsv_pkg::IDX_CMD))
      cmd_q <= wr_data_i[rsv_pkg::CMD_W-1:0];
    else
      cmd_q <= '0;
  end

  assign rd_data_o   = rd_data_q;
  assign rd_valid_o  = rd_valid_q;
  assign ctrl_o      = ctrl_q;
  assign cmd_pulse_o = cmd_q;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  logic [rsv_pkg::DATA_W-1:0] wd_hist_q;
  always_ff @(posedge sys_clk_i)
  begin
    wd_hist_q <= wr_data_i;
  end

  sequence rd_ctrl_clean;
    rd_en_i && hit(addr_i, rsv_pkg::IDX_CTRL) && !wr_en_i && !ind_we_i;
  endsequence

  a_one_field_reads: assert property (
    rd_en_i && hit(addr_i, rsv_pkg::IDX_MODE) |=> rd_data_o[1:0] == 2'b11)
    else $error("read-as-one field did not read ones");

  a_zero_field_reads: assert property (
    rd_en_i && hit(addr_i, rsv_pkg::IDX_MODE) |=> rd_data_o[3:2] == 2'b00)
    else $error("read-as-zero field did not read zeros");

  a_const_rsv_bits: assert property (
    rd_en_i && hit(addr_i, rsv_pkg::IDX_CTRL) |=>
      !rd_data_o[rsv_pkg::CTRL_R0C] && rd_data_o[rsv_pkg::CTRL_R1C])
    else $error("constant reserved bits read wrong value");

  // A write is followed by one quiet cycle before the read is taken, the
  // shape in which a driver that sets its strobe after an edge reads back.
  a_indirect_force: assert property (
    (ind_we_i && hit(ind_addr_i, rsv_pkg::IDX_CTRL) && !wr_en_i)
      ##1 (!wr_en_i && !ind_we_i) ##1 rd_ctrl_clean |=>
      !rd_data_o[rsv_pkg::CTRL_R0S] && rd_data_o[rsv_pkg::CTRL_R1S])
    else $error("indirect write did not force reserved bits");

  a_direct_store: assert property (
    (wr_en_i && hit(addr_i, rsv_pkg::IDX_CTRL))
      ##1 (!wr_en_i && !ind_we_i) ##1 rd_ctrl_clean |=>
      rd_data_o[6:5] == $past(wd_hist_q[6:5], 2))
    else $error("direct write not held by reserved storage");

  a_rsv_no_effect: assert property (
    ##1 (ctrl_o[7:4] == 4'h0 && ctrl_o[11:8] == 4'h0))
    else $error("reserved bit reached control output");

  a_ctx_gating: assert property (
    $past(ctx_rsv_i) |-> ctrl_o[15:12] == 4'h0)
    else $error("context-reserved bits leaked while reserved");

  a_ro_rsv_zero: assert property (
    rd_en_i && hit(addr_i, rsv_pkg::IDX_STAT) |=>
      rd_data_o == {4'h0, $past(status_i)})
    else $error("status register read wrong");

  a_unmapped_zero: assert property (
    rd_en_i && (addr_i > rsv_pkg::IDX_LAST || hit(addr_i, rsv_pkg::IDX_CMD))
      |=> rd_data_o == rsv_pkg::ZERO_D && rd_valid_o)
    else $error("unmapped or write-only read not zero");

  // The pulse may only stay up when a second command write follows.
  a_cmd_pulse: assert property (
    wr_en_i && hit(addr_i, rsv_pkg::IDX_CMD) |=>
      cmd_pulse_o == $past(wr_data_i[3:0]) ##1
      (cmd_pulse_o == 4'h0 ||
       $past(wr_en_i && hit(addr_i, rsv_pkg::IDX_CMD))))
    else $error("command pulse wrong");

  c_ctrl_write_read: cover property (
    (wr_en_i && hit(addr_i, rsv_pkg::IDX_CTRL))
      ##1 (!wr_en_i && !ind_we_i) ##1 rd_ctrl_clean);
  c_indirect_ctrl: cover property (
    (ind_we_i && hit(ind_addr_i, rsv_pkg::IDX_CTRL))
      ##1 (!wr_en_i && !ind_we_i) ##1 rd_ctrl_clean);
  c_ctx_toggle: cover property (ctx_rsv_i ##1 !ctx_rsv_i);
  c_cmd_write: cover property (wr_en_i && hit(addr_i, rsv_pkg::IDX_CMD));

endmodule

`default_nettype wire

// file: testbench/rsv_tb.sv
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------
  // Stimulus and observation signals
  // ---------------------------------------------------------------------
  logic                         sys_clk_i;
  logic                         reset_i;
  logic                         wr_en_i;
  logic                         rd_en_i;
  logic [rsv_pkg::ADDR_W-1:0]   addr_i;
  logic [rsv_pkg::DATA_W-1:0]   wr_data_i;
  logic                         ind_we_i;
  logic [rsv_pkg::ADDR_W-1:0]   ind_addr_i;
  logic [rsv_pkg::DATA_W-1:0]   ind_data_i;
  logic                         ctx_rsv_i;
  logic [rsv_pkg::STAT_W-1:0]   status_i;
  logic [rsv_pkg::DATA_W-1:0]   rd_data_o;
  logic                         rd_valid_o;
  logic [2*rsv_pkg::DATA_W-1:0] ctrl_o;
  logic [rsv_pkg::CMD_W-1:0]    cmd_pulse_o;
  int                           bad_count;
  int                           n_compared;
  int                           cycles;

  rsv_regbank DUT (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .wr_en_i     (wr_en_i),
    .rd_en_i     (rd_en_i),
    .addr_i      (addr_i),
    .wr_data_i   (wr_data_i),
    .ind_we_i    (ind_we_i),
    .ind_addr_i  (ind_addr_i),
    .ind_data_i  (ind_data_i),
    .ctx_rsv_i   (ctx_rsv_i),
    .status_i    (status_i),
    .rd_data_o   (rd_data_o),
    .rd_valid_o  (rd_valid_o),
    .ctrl_o      (ctrl_o),
    .cmd_pulse_o (cmd_pulse_o)
  );

  // 50 MHz clock; the run is short, so a few thousand cycles cap a hang.
  always #10 sys_clk_i = ~sys_clk_i;

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask

  // A write is taken at the first edge after the strobe rises.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_en_i   <= 1'b1;
    addr_i    <= a;
    wr_data_i <= d;
    @(posedge sys_clk_i);
    wr_en_i   <= 1'b0;
    wr_data_i <= ~d;
  endtask

  task automatic ind(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    ind_we_i   <= 1'b1;
    ind_addr_i <= a;
    ind_data_i <= d;
    @(posedge sys_clk_i);
    ind_we_i   <= 1'b0;
    ind_data_i <= ~d;
  endtask

  // The answer stands for one cycle after the edge that takes the read.
  task automatic rd_expect(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    rd_en_i <= 1'b1;
    addr_i  <= a;
    @(posedge sys_clk_i);
    rd_en_i <= 1'b0;
    #1;
    check({15'h0000, rd_valid_o}, 16'h0001, "read valid");
    check({8'h00, rd_data_o}, {8'h00, exp}, "read data");
  endtask

  // Lets the registered field outputs settle after a change.
  task automatic settle;
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic test_reset_values;
    rd_expect(rsv_pkg::IDX_CTRL, 8'hc0);
    rd_expect(rsv_pkg::IDX_MODE, 8'hc3);
    $display("test reset values done");
  endtask

  task automatic test_ctrl_direct;
    wr(rsv_pkg::IDX_CTRL, 8'hff);
    rd_expect(rsv_pkg::IDX_CTRL, 8'hef);
    settle();
    check({8'h00, ctrl_o[7:0]}, 16'h000f, "ctrl use");
    wr(rsv_pkg::IDX_CTRL, 8'h00);
    rd_expect(rsv_pkg::IDX_CTRL, 8'h80);
    $display("test direct writes done");
  endtask

  task automatic test_ctrl_indirect;
    wr(rsv_pkg::IDX_CTRL, 8'h20);
    rd_expect(rsv_pkg::IDX_CTRL, 8'ha0);
    ind(rsv_pkg::IDX_CTRL, 8'h35);
    rd_expect(rsv_pkg::IDX_CTRL, 8'hc5);
    $display("test indirect writes done");
  endtask

  // The context qualifier only ever changes on a rising edge.
  task automatic test_mode_fields;
    @(posedge sys_clk_i);
    ctx_rsv_i <= 1'b0;
    wr(rsv_pkg::IDX_MODE, 8'h00);
    rd_expect(rsv_pkg::IDX_MODE, 8'h03);
    wr(rsv_pkg::IDX_MODE, 8'hff);
    rd_expect(rsv_pkg::IDX_MODE, 8'hf3);
    @(posedge sys_clk_i);
    ctx_rsv_i <= 1'b1;
    wr(rsv_pkg::IDX_MODE, 8'ha5);
    rd_expect(rsv_pkg::IDX_MODE, 8'ha3);
    settle();
    check({8'h00, ctrl_o[15:8]}, 16'h0000, "mode off");
    @(posedge sys_clk_i);
    ctx_rsv_i <= 1'b0;
    settle();
    check({8'h00, ctrl_o[15:8]}, 16'h00a0, "mode on");
    rd_expect(rsv_pkg::IDX_MODE, 8'ha3);
    @(posedge sys_clk_i);
    ctx_rsv_i <= 1'b1;
    ind(rsv_pkg::IDX_MODE, 8'h5f);
    rd_expect(rsv_pkg::IDX_MODE, 8'hc3);
    @(posedge sys_clk_i);
    ctx_rsv_i <= 1'b0;
    ind(rsv_pkg::IDX_MODE, 8'h50);
    rd_expect(rsv_pkg::IDX_MODE, 8'h53);
    $display("test mode fields done");
  endtask

  task automatic test_other_regs;
    @(posedge sys_clk_i);
    status_i <= 4'ha;
    wr(rsv_pkg::IDX_STAT, 8'hff);
    rd_expect(rsv_pkg::IDX_STAT, 8'h0a);
    @(posedge sys_clk_i);
    status_i <= 4'h5;
    rd_expect(rsv_pkg::IDX_STAT, 8'h05);
    wr(rsv_pkg::IDX_CMD, 8'hf5);
    #1;
    check({12'h000, cmd_pulse_o}, 16'h0005, "command pulse");
    @(posedge sys_clk_i);
    #1;
    check({12'h000, cmd_pulse_o}, 16'h0000, "command end");
    rd_expect(rsv_pkg::IDX_CMD, 8'h00);
    for (int a = 4; a < 8; a++)
    begin
      wr(3'(a), 8'hff);
      rd_expect(3'(a), 8'h00);
    end
    rd_expect(rsv_pkg::IDX_CTRL, 8'hc5);
    $display("test other registers done");
  endtask

  // A well-behaved driver: reserved positions go back as last read, fixed
  // fields with their constant, write-only reserved bits as zero.
  task automatic test_preserve_writes;
    wr(rsv_pkg::IDX_CTRL, 8'hca);
    rd_expect(rsv_pkg::IDX_CTRL, 8'hca);
    wr(rsv_pkg::IDX_MODE, 8'h63);
    rd_expect(rsv_pkg::IDX_MODE, 8'h63);
    wr(rsv_pkg::IDX_CMD, 8'h0a);
    #1;
    check({12'h000, cmd_pulse_o}, 16'h000a, "command kept");
    $display("test preserve writes done");
  endtask

  // ---------------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ---------------------------------------------------------------------
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Cuts a hang short well beyond the hundred or so cycles the run needs.
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  initial
  begin
    sys_clk_i  = 1'b0;
    reset_i    = 1'b1;
    wr_en_i    = 1'b0;
    rd_en_i    = 1'b0;
    addr_i     = 3'h0;
    wr_data_i  = 8'h00;
    ind_we_i   = 1'b0;
    ind_addr_i = 3'h0;
    ind_data_i = 8'h00;
    ctx_rsv_i  = 1'b0;
    status_i   = 4'h0;
    bad_count  = 0;
    n_compared = 0;
    cycles     = 0;
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    test_reset_values();
    test_ctrl_direct();
    test_ctrl_indirect();
    test_mode_fields();
    test_other_regs();
    test_preserve_writes();
    give_verdict();
  end
endmodule

`default_nettype wire
